// ---- logic/crc_engine.sv ----
// serial crc shifter fed from the word stream
`timescale 1ns/1ns
module crc_engine
	import crc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic go,
	input wire logic [3:0] plen,
	input wire logic [15:0] poly,
	crc_word_if.dst in,
	output logic [15:0] result
);
	shift_state_t state_ff;
	logic [3:0] bit_ff;
	logic [15:0] crc_ff;
	logic fb;
	logic [15:0] shifted;
	logic [15:0] lenmask;

	// feedback is the top crc bit (bit plen) xored with the data msb first
	always_comb
	begin
		lenmask = 16'((17'h1 << ({1'b0, plen} + 5'h1)) - 17'h1); // [R14]
		fb = crc_ff[plen] ^ in.word[plen - bit_ff];
		shifted = {crc_ff[14:0], 1'b0} ^ ({poly[15:1], 1'b1} & {16{fb}}); // [R8]
	end
	assign result = crc_ff;
	// no word may be taken from an empty queue, or the count would underflow
	assign in.take = (state_ff == SHIFT_RUN) && in.avail && (bit_ff == plen); // [R11]

	// shifter: one bit per clock, plen+1 clocks per word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= SHIFT_IDLE;
			bit_ff <= 4'h0;
			crc_ff <= 16'h0000;
		end
		else if (run) // [R1] [R3]
		begin
			case (state_ff)
				SHIFT_IDLE:
				begin
					bit_ff <= 4'h0;
					if (go && in.avail) // [R7] [R11]
					begin
						state_ff <= SHIFT_RUN;
					end
				end
				SHIFT_RUN:
				begin
					// an empty queue ends the run before any bit is taken, so the
					// result never absorbs a word that was not written; clearing
					// go lets the queued words drain first
					if (!in.avail)
					begin
						bit_ff <= 4'h0;
						state_ff <= SHIFT_IDLE; // [R7] [R11]
					end
					else
					begin
						crc_ff <= shifted & lenmask;
						if (bit_ff == plen)
						begin
							bit_ff <= 4'h0;
						end
						else
						begin
							bit_ff <= bit_ff + 4'h1;
						end
					end
				end
				default:
				begin
					state_ff <= SHIFT_IDLE;
				end
			endcase
		end
	end
endmodule : crc_engine

// ---- logic/crc_fifo.sv ----
// word fifo with the count, full and wrap behaviour of the crc unit
`timescale 1ns/1ns
module crc_fifo
	import crc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic wr,
	input wire logic [15:0] wdata,
	input wire logic [3:0] plen,
	crc_word_if.src out,
	output logic [4:0] count,
	output logic full,
	output logic drained
);
	logic [15:0] mem [FIFO_SLOTS];
	logic [3:0] wp_ff;
	logic [3:0] rp_ff;
	logic [4:0] count_ff;
	logic [4:0] depth;
	logic wrap;
	logic pop;

	// ****************************************************************
	// depth and flags
	// ****************************************************************
	assign depth = (plen > WIDE_LIMIT) ? DEPTH_WIDE : DEPTH_NARROW; // [R5]
	assign full = (count_ff == depth); // [R6]
	assign wrap = wr && full; // [R13]
	assign pop = out.take && run;
	assign count = count_ff;
	assign out.avail = (count_ff != 5'h00);
	assign out.word = mem[rp_ff];
	// a pop sharing a cycle with a wrap is lost on purpose: the wrap empties all
	assign drained = pop && (count_ff == 5'h01) && !wr; // [R12]

	// storage; gated by run so a stopped clock domain holds every word
	always_ff @(posedge hclk)
	begin
		if (run && wr && !full)
		begin
			mem[wp_ff] <= wdata;
		end
	end

	// pointers and valid word count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp_ff <= 4'h0;
			rp_ff <= 4'h0;
			count_ff <= COUNT_RESET;
		end
		else if (run) // [R1] [R3]
		begin
			if (wrap)
			begin
				wp_ff <= 4'h0; // [R13]
				rp_ff <= 4'h0;
				count_ff <= 5'h00;
			end
			else
			begin
				if (wr)
				begin
					wp_ff <= wp_ff + 4'h1;
				end
				if (pop)
				begin
					rp_ff <= rp_ff + 4'h1;
				end
				count_ff <= 5'(count_ff + {4'h0, wr} - {4'h0, pop}); // [R10] [R11]
			end
		end
	end
endmodule : crc_fifo

// ---- logic/crc_pkg.sv ----
// constants, field layout and register map of the programmable crc generator
// How it works
// [R1] sleep freezes fifo, shifter and result
// [R2] software clears idle-stop before idle
// [R3] idle-stop set: freeze in idle, forward interrupts
// [R4] idle-stop bit 13, read/write, resets zero
// [R5] word count bits 12:8, max 8 or 16
// [R6] full flag bit 7, empty bit 6
// [R7] go bit 4 starts; clear drains then stops
// [R8] polynomial term enables bits 15:1
// [R9] unimplemented bits read zero, ignore writes
// [R10] data write increments word count
// [R11] shift length+1 clocks per word, then decrement
// [R12] interrupt when word count goes 1 to 0
// [R13] write while full wraps count, no interrupt
// [R14] length field sets degree and element width
// [R15] data read returns crc when empty
package crc_pkg;
	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_POLY = 4'h4;
	localparam logic [3:0] ADDR_DATA = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'hc;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h0 + 4'h0 + 4'h0 + 4'h0;
	// ****************************************************************
	// control field positions and masks
	// ****************************************************************
	localparam int IDLE_STOP_POS = 13;
	localparam int COUNT_LSB = 8;
	localparam int FULL_POS = 7;
	localparam int EMPTY_POS = 6;
	localparam int GO_POS = 4;
	localparam logic [15:0] CONTROL_WMASK = 16'h201f;
	localparam logic [15:0] POLY_WMASK = 16'hfffe;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] POLY_RESET = 16'h0000;
	localparam logic [4:0] DEPTH_WIDE = 5'h08;
	localparam logic [4:0] DEPTH_NARROW = 5'h10;
	localparam logic [3:0] WIDE_LIMIT = 4'h7;
	localparam logic [4:0] COUNT_RESET = 5'h00;
	localparam int FIFO_SLOTS = 16;
	localparam logic [31:0] MASK_ADDR_WORD = 32'h0000_0010;
	typedef enum logic [1:0] {SHIFT_IDLE = 2'b00, SHIFT_RUN = 2'b01} shift_state_t;
endpackage : crc_pkg

// ---- logic/crc_top.sv ----
// ahb-lite register slave and power gating of the crc generator
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module crc_top
	import crc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic sleep_req,
	input wire logic idle_req,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq
);
	logic [15:0] ctrl_ff;
	logic [15:0] poly_ff;
	logic status_ff;
	logic mask_ff;
	logic wr_pend_ff;
	logic [3:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic irq_ff;
	logic haddr_hi_ff;
	logic wr_mask_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic run;
	logic data_wr;
	logic [4:0] count;
	logic full;
	logic drained;
	logic [15:0] result;
	logic [15:0] ctrl_view;
	logic [31:0] nxt_rdata;
	logic rd_req;
	crc_word_if link ();

	// ****************************************************************
	// clock gating equivalent
	// ****************************************************************
	// held state stands for a stopped clock; the bus side stays live
	assign run = !sleep_req && !(idle_req && ctrl_ff[IDLE_STOP_POS]); // [R1] [R3]
	// aliases above the first page must not push words into the queue
	assign data_wr = wr_pend_ff && (wr_addr_ff == ADDR_DATA) && !haddr_hi_ff;
	assign rd_req = hsel && hready && htrans[1] && !hwrite;

	crc_fifo u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run),
		.wr(data_wr && run), // [R10]
		.wdata(hwdata[15:0]),
		.plen(ctrl_ff[3:0]),
		.out(link.src),
		.count(count),
		.full(full),
		.drained(drained)
	);

	crc_engine u_engine (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run),
		.go(ctrl_ff[GO_POS]),
		.plen(ctrl_ff[3:0]),
		.poly(poly_ff),
		.in(link.dst),
		.result(result)
	);

	// ****************************************************************
	// bus slave
	// ****************************************************************
	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 4'h0;
		end
		else
		begin
			wr_pend_ff <= hsel && hready && htrans[1] && hwrite;
			wr_addr_ff <= haddr[3:0];
		end
	end

	// upper address bits of the pending write; only the first page holds registers, apart from the mask word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			haddr_hi_ff <= 1'b0;
		end
		else
		begin
			haddr_hi_ff <= (haddr[31:4] != 28'h0);
		end
	end

	// exact match of the mask word, so unmapped aliases never reach the mask
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_mask_ff <= 1'b0;
		end
		else
		begin
			wr_mask_ff <= (haddr == MASK_ADDR_WORD);
		end
	end

	// control view: live status fields over stored control bits
	always_comb
	begin
		ctrl_view = ctrl_ff & CONTROL_WMASK; // [R9]
		ctrl_view[12:8] = count; // [R5]
		ctrl_view[FULL_POS] = full; // [R6]
		ctrl_view[EMPTY_POS] = (count == 5'h00); // [R6]
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (haddr[3:0] == ADDR_CONTROL)
		begin
			nxt_rdata = {16'h0000, ctrl_view};
		end
		else if (haddr[3:0] == ADDR_POLY)
		begin
			nxt_rdata = {16'h0000, poly_ff & POLY_WMASK}; // [R9]
		end
		else if (haddr[3:0] == ADDR_DATA)
		begin
			nxt_rdata = {16'h0000, result}; // [R15]
		end
		else if (haddr[3:0] == ADDR_IRQ_STATUS)
		begin
			nxt_rdata = {31'h0, status_ff};
		end
		if (haddr[4])
		begin
			nxt_rdata = {31'h0, mask_ff};
		end
		if (haddr[31:5] != 27'h0 || (haddr[4] && haddr[3:0] != 4'h0))
		begin
			nxt_rdata = 32'h0000_0000;
		end
	end

	// read data registered at the address phase, shown in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_ff <= 32'h0000_0000;
		end
		else if (rd_req)
		begin
			hrdata_ff <= nxt_rdata;
		end
	end

	// control register; writes land in the data phase, and stay open while
	// the unit is frozen so software can still change the idle-stop choice
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_ff <= CONTROL_RESET; // [R4] [R7]
		end
		else if (wr_pend_ff && wr_addr_ff == ADDR_CONTROL && !haddr_hi_ff)
		begin
			ctrl_ff <= hwdata[15:0] & CONTROL_WMASK; // [R4] [R7] [R9]
		end
	end

	// polynomial term enables; term 0 is wired into the shifter itself
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			poly_ff <= POLY_RESET; // [R8]
		end
		else if (wr_pend_ff && wr_addr_ff == ADDR_POLY && !haddr_hi_ff)
		begin
			poly_ff <= hwdata[15:0] & POLY_WMASK; // [R8] [R9]
		end
	end

	// ****************************************************************
	// interrupt
	// ****************************************************************
	// the drain event cannot fire while frozen, since pop is gated by run, and
	// a pending bit is still forwarded to irq while the unit is stopped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_ff <= 1'b0;
		end
		else if (drained)
		begin
			status_ff <= 1'b1; // [R12] set wins over clear
		end
		else if (wr_pend_ff && wr_addr_ff == ADDR_IRQ_STATUS && !haddr_hi_ff && hwdata[0])
		begin
			status_ff <= 1'b0;
		end
	end

	// interrupt mask; only the exact mask word writes it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mask_ff <= 1'b0;
		end
		else if (wr_pend_ff && wr_mask_ff)
		begin
			mask_ff <= hwdata[0];
		end
	end

	// registered interrupt level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= status_ff && mask_ff; // [R3]
		end
	end

	// ****************************************************************
	// bus response
	// ****************************************************************
	// this slave never stalls and never errs; the response still comes from
	// flops so the bus sees no combinational path through the slave
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end
		else
		begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign irq = irq_ff;
endmodule : crc_top

// ---- logic/crc_word_if.sv ----
// word stream between the fifo and the crc shifter
`timescale 1ns/1ns
interface crc_word_if;
	logic [15:0] word;
	logic avail;
	logic take;
	modport src (output word, output avail, input take);
	modport dst (input word, input avail, output take);
endinterface : crc_word_if

// ---- verification/crc_top_asserts.sv ----
// port checker of the crc register slave
`timescale 1ns/1ns
module crc_top_asserts
	import crc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic sleep_req,
	input wire logic idle_req,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic ph_ff;
	logic wr_ff;
	logic [31:0] ad_ff;
	logic rd;
	logic wr;
	logic ct;
	// remember the address phase so the data phase can be judged
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ph_ff <= 1'b0;
		else
		begin
			ph_ff <= hsel && hready && htrans[1];
			wr_ff <= hwrite;
			ad_ff <= haddr;
		end
	assign rd = ph_ff && !wr_ff;
	assign wr = ph_ff && wr_ff;
	assign ct = rd && ad_ff == 32'h0;
	// ****************************************************************
	// properties
	// ****************************************************************
	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("slave stalled or erred");
	property p_upper;
		rd |-> hrdata[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper half set");
	property p_gaps;
		ct |-> hrdata[15:14] == 2'h0 && !hrdata[5];
	endproperty
	a_gaps: assert property (p_gaps) else $error("control gap set");
	property p_bit0;
		rd && ad_ff == 32'h4 |-> !hrdata[0];
	endproperty
	a_bit0: assert property (p_bit0) else $error("term bit 0 set");
	property p_empty;
		ct |-> hrdata[6] == (hrdata[12:8] == 5'h00);
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag wrong");
	property p_full;
		ct |-> hrdata[7] == (hrdata[12:8] == (hrdata[3:0] > 4'h7 ? 5'h08 : 5'h10));
	endproperty
	a_full: assert property (p_full) else $error("full flag wrong");
	property p_max;
		ct |-> hrdata[12:8] <= (hrdata[3:0] > 4'h7 ? 5'h08 : 5'h10);
	endproperty
	a_max: assert property (p_max) else $error("count over depth");
	property p_unmapped;
		rd && ad_ff > MASK_ADDR_WORD |-> hrdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	// a frozen unit cannot raise or drop its request by itself; only a bus write to the status or mask moves it
	property p_freeze;
		sleep_req [*3] |-> $stable(irq);
	endproperty
	a_freeze: assert property (p_freeze) else $error("irq moved in sleep");
	property p_mask;
		(wr && ad_ff == MASK_ADDR_WORD && !hwdata[0] && !sleep_req && !idle_req)
			##1 (!sleep_req && !idle_req) |=> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq high");
endmodule : crc_top_asserts
bind crc_top crc_top_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .sleep_req, .idle_req, .hrdata, .hreadyout, .hresp, .irq);

// ---- verification/crc_top_bench.sv ----
// self-checking bench of the crc generator
`timescale 1ns/1ns
module crc_top_bench
	import crc_pkg::*;
;
	localparam logic [31:0] PL = 32'h4;
	localparam logic [31:0] DT = 32'h8;
	localparam logic [31:0] ST = 32'hc;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic sleep_req = 1'b0;
	logic idle_req = 1'b0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	logic irq;
	int bad_count = 0;
	int compares = 0;
	always #50 hclk = ~hclk;
	crc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .sleep_req, .idle_req, .hrdata, .hreadyout, .hresp(), .irq);
	// ****************************************************************
	// helpers
	// ****************************************************************
	task results;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one single ahb-lite transfer; read data lands in rd
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask : xfer
	task rchk(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk
	// bounded wait, so a dead shifter cannot hang the run
	task wirq(input logic e, input int n);
		repeat (n)
			if (irq !== e)
				@(posedge hclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : wirq
	// msb-first serial model, term 0 always fed back
	function automatic logic [15:0] crc_next(logic [15:0] c, logic [15:0] d, int n);
		logic fb;
		for (int i = n - 1; i >= 0; i--)
		begin
			fb = c[n - 1] ^ d[i];
			c = (c << 1) & ((16'h1 << n) - 16'h1);
			if (fb)
				c = c ^ 16'h7;
		end
		return c;
	endfunction : crc_next
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_regs;
		rchk(32'h0, 32'h40);
		rchk(PL, 32'h0);
		xfer(1'b1, 32'h0, 32'hffff_ffff);
		rchk(32'h0, 32'h205f);
		xfer(1'b1, PL, 32'hffff_ffff);
		rchk(PL, 32'hfffe);
		xfer(1'b1, 32'h0, 32'h0);
		xfer(1'b1, 32'h20, 32'hffff_ffff);
		rchk(32'h20, 32'h0);
		rchk(MASK_ADDR_WORD, 32'h0);
	endtask : t_regs
	task t_crc;
		xfer(1'b1, MASK_ADDR_WORD, 32'h1);
		xfer(1'b1, PL, 32'h6);
		xfer(1'b1, 32'h0, 32'h7);
		xfer(1'b1, DT, 32'h5a);
		xfer(1'b1, DT, 32'hc3);
		rchk(32'h0, 32'h207);
		xfer(1'b1, 32'h0, 32'h17);
		wirq(1'b1, 40);
		rchk(ST, 32'h1);
		rchk(DT, {16'h0, crc_next(crc_next(16'h0, 16'h5a, 8), 16'hc3, 8)});
		rchk(32'h0, 32'h57);
		xfer(1'b1, ST, 32'h1);
		wirq(1'b0, 3);
	endtask : t_crc
	task t_wrap;
		for (int p = 7; p <= 8; p++)
		begin
			xfer(1'b1, 32'h0, p);
			repeat (p > 7 ? 8 : 16)
				xfer(1'b1, DT, 32'h1);
			rchk(32'h0, ((p > 7 ? 8 : 16) << 8) | 32'h80 | p);
			xfer(1'b1, DT, 32'h1);
			rchk(32'h0, 32'h40 | p);
			rchk(ST, 32'h0);
		end
	endtask : t_wrap
	// 0 sleep, 1 idle with stop bit, 2 idle without it
	task t_freeze;
		logic [15:0] c;
		c = crc_next(crc_next(16'h0, 16'h5a, 8), 16'hc3, 8);
		for (int m = 0; m < 3; m++)
		begin
			xfer(1'b1, 32'h0, m == 1 ? 32'h200f : 32'hf);
			xfer(1'b1, DT, 32'h1);
			xfer(1'b1, DT, 32'h2);
			xfer(1'b1, 32'h0, m == 1 ? 32'h201f : 32'h1f);
			repeat (4) @(posedge hclk);
			sleep_req <= m == 0;
			idle_req <= m != 0;
			if (m == 2)
				wirq(1'b1, 60);
			else
				repeat (40)
				begin
					@(posedge hclk);
					chk({31'h0, irq}, 32'h0);
				end
			sleep_req <= 1'b0;
			idle_req <= 1'b0;
			wirq(1'b1, 60);
			c = crc_next(crc_next(c, 16'h1, 16), 16'h2, 16);
			rchk(DT, {16'h0, c});
			xfer(1'b1, ST, 32'h1);
		end
		xfer(1'b1, MASK_ADDR_WORD, 32'h0);
		wirq(1'b0, 3);
	endtask : t_freeze
	initial
	begin
		#(20000 * 100);
		bad_count++;
		$display("[FAIL] %0t watchdog", $time);
		results;
	end
	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_crc;
		t_wrap;
		t_freeze;
		results;
	end
endmodule : crc_top_bench
